/* File: verilog/sef_pkg.sv */
/*
  Shared constants and types of the serial interface event-flag block:
  control bit positions, reset values, link timing figures and the
  master sequencer states.
  Assumes a single system clock of CLK_NS nanoseconds.
*/
`default_nettype none

package sef_pkg;

  // System clock period
  localparam int CLK_NS = 10;

  // Bit positions inside serial_control_reg
  localparam int XFER_BIT    = 7;
  localparam int WRITE_COLLISION_FLAG_BIT    = 6;
  localparam int MODE_FAULT_FLAG_BIT    = 5;
  localparam int OVR_BIT     = 4;
  localparam int MODE_HI_BIT = 3;
  localparam int MODE_LO_BIT = 2;
  localparam int MST_BIT     = 1;
  localparam int EN_BIT      = 0;

  // Slave-select mode encodings
  localparam logic [1:0] SS_MODE_3W = 2'h0;
  localparam logic [1:0] SS_MODE_4W = 2'h1;

  // Reset values
  localparam logic [1:0] SS_MODE_RST  = SS_MODE_4W;
  localparam logic       IFACE_EN_RST = 1'h0;
  localparam logic       MST_EN_RST   = 1'h0;

  localparam int BYTE_BITS = 8;
  localparam int CNT_W     = 4;
  localparam int DIV_W     = 8;

  // Link timing, in nanoseconds, and derived cycle counts
  localparam int MST_SCK_MIN_NS     = 1 * CLK_NS;
  localparam int MST_SCK_MIN_CYC    = (MST_SCK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLV_SCK_MIN_NS     = 5 * CLK_NS;
  localparam int SLV_SCK_MIN_CYC    = (SLV_SCK_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SS_LEAD_MIN_NS     = 2 * CLK_NS;
  localparam int SS_LEAD_MIN_CYC    = (SS_LEAD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int MOSI_HOLD_MIN_NS   = 2 * CLK_NS;
  localparam int MOSI_HOLD_MIN_CYC  = (MOSI_HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int MISO_VALID_MAX_NS  = 4 * CLK_NS;
  localparam int MISO_VALID_MAX_CYC = MISO_VALID_MAX_NS / CLK_NS;
  localparam int MISO_SHIFT_MAX_NS  = 4 * CLK_NS;
  localparam int MISO_SHIFT_MAX_CYC = MISO_SHIFT_MAX_NS / CLK_NS;

  // Default master half period; covers the MISO synchroniser delay
  localparam int MST_HALF_DEF = 4;

  typedef enum logic {
    SEF_IDLE,
    SEF_RUN
  } sef_mst_t;

endpackage

`default_nettype wire

/* File: verilog/sef_sync.sv */
/*
  Two-flop level synchroniser, W bits wide, into the system clock.
  Assumes each bit is a level that changes far slower than clk_sys.
*/
`default_nettype none
`timescale 1ns/1ps

module sef_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sef_sync_t;

  sef_sync_t r_q;
  sef_sync_t r_d;

  // First stage is read only by the second
  always_comb begin
    r_d    = r_q;
    r_d.s1 = d;
    r_d.s2 = r_q.s1;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign q = r_q.s2;

endmodule

`default_nettype wire

/* File: verilog/sef_core.sv */
/*
  Byte-wide serial interface, master or slave, with its four sticky
  event flags, transmit and receive buffers and link timing.
  Assumes software strobes are one clk_sys cycle long and that an
  external master keeps the slave-side link timing.
*/
// What this block does
// - Set transfer-complete flag at the end of every byte, any mode.
// - Set write-collision flag on data write while transmit buffer still full.
// - A colliding data write is dropped; transmit buffer keeps old byte.
// - Set mode-fault flag when multimaster master sees slave-select low.
// - Mode fault clears master enable and interface enable.
// - Slave sets receive-overrun flag when byte ends with unread receive byte.
// - On overrun the old receive byte stays; the new byte is lost.
// - Flags request interrupt when enabled; only software clears them.
// - Master serial clock high and low each at least one system clock.
// - Slave MISO valid or released within four clocks of slave-select.
// - Slave MISO updates within four clocks of each shift edge.
// - Four-wire slave works only with slave-select low; falling edge clears count.
// - Slave-select mode 01 selects four-wire slave operation, the default.
`default_nettype none
`timescale 1ns/1ps

module sef_core
  import sef_pkg::*;
#(
  parameter int DW       = BYTE_BITS,
  parameter int HALF_CYC = MST_HALF_DEF
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          spi_sck,
  output logic               sck_o,
  output logic               sck_oe,
  input  wire logic          mosi_i,
  output logic               mosi_o,
  output logic               mosi_oe,
  input  wire logic          miso_i,
  output logic               miso_o,
  output logic               miso_oe,
  input  wire logic          slave_select_n,
  input  wire logic          ctrl_wr,
  input  wire logic [7:0]    ctrl_wdata,
  output logic      [7:0]    serial_control_reg,
  input  wire logic          data_wr,
  input  wire logic [DW-1:0] data_wdata,
  input  wire logic          data_rd,
  output logic      [DW-1:0] serial_data_reg,
  input  wire logic          int_en,
  output logic               irq,
  output logic               busy
);

  // The master half period never drops below the documented minimum
  localparam int HALF_EFF = (HALF_CYC < MST_SCK_MIN_CYC) ? MST_SCK_MIN_CYC : HALF_CYC;
  localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_EFF - 1);
  localparam logic [CNT_W-1:0] LAST_BIT  = CNT_W'(DW - 1);

  function automatic logic [DW-1:0] shl_in(input logic [DW-1:0] v, input logic b);
    shl_in = {v[DW-2:0], b};
  endfunction

  // Link-clock domain: MOSI is captured on the sample edge, a toggle
  // announces it. The bit stays put until the next rising edge, which
  // is at least ten system clocks away, so the toggle covers it.
  typedef struct packed {
    logic tgl;
    logic bit_v;
  } sef_lnk_t;

  sef_lnk_t l_q;
  sef_lnk_t l_d;

  always_comb begin
    l_d       = l_q;
    l_d.tgl   = ~l_q.tgl;
    l_d.bit_v = mosi_i;
  end

  always_ff @(posedge spi_sck or negedge rst_b) begin
    if (!rst_b) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  logic s_sck;
  logic s_sel;
  logic s_nss;
  logic s_miso;
  logic s_tgl;

  // Synchroniser clears to 0; carrying the select active high keeps
  // a false select edge from following reset
  assign s_nss = ~s_sel;

  sef_sync #(
    .W (4)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .d       ({spi_sck, ~slave_select_n, miso_i, l_q.tgl}),
    .q       ({s_sck, s_sel, s_miso, s_tgl})
  );

  typedef struct packed {
    logic              iface_en;
    logic              mst_en;
    logic [1:0]        ss_mode;
    logic              f_done;
    logic              f_write_collision_flag;
    logic              f_mode_fault_flag;
    logic              f_ovr;
    logic [DW-1:0]     tx_buf;
    logic              tx_full;
    logic [DW-1:0]     tx_sh;
    logic [DW-1:0]     rx_sh;
    logic [DW-1:0]     rx_buf;
    logic              rx_full;
    logic [CNT_W-1:0]  cnt;
    logic              sl_busy;
    sef_mst_t          mst;
    logic [DIV_W-1:0]  div;
    logic              sck;
    logic              drv_mst;
    logic              drv_slv;
    logic              pv_sck;
    logic              pv_nss;
    logic              pv_tgl;
  } sef_st_t;

  localparam sef_st_t ST_RST = '{
    iface_en : IFACE_EN_RST,
    mst_en   : MST_EN_RST,
    ss_mode  : SS_MODE_RST,
    f_done   : 1'h0,
    f_write_collision_flag   : 1'h0,
    f_mode_fault_flag   : 1'h0,
    f_ovr    : 1'h0,
    tx_buf   : '0,
    tx_full  : 1'h0,
    tx_sh    : '0,
    rx_sh    : '0,
    rx_buf   : '0,
    rx_full  : 1'h0,
    cnt      : '0,
    sl_busy  : 1'h0,
    mst      : SEF_IDLE,
    div      : '0,
    sck      : 1'h0,
    drv_mst  : 1'h0,
    drv_slv  : 1'h0,
    pv_sck   : 1'h0,
    pv_nss   : 1'h1,
    pv_tgl   : 1'h0
  };

  sef_st_t s_q;
  sef_st_t s_d;

  always_comb begin
    logic          four_w;
    logic          slave_on;
    logic          nss_fall;
    logic          smp_ev;
    logic          shf_ev;
    logic          done;
    logic          from_slv;
    logic [DW-1:0] nb;

    s_d      = s_q;
    done     = 1'h0;
    from_slv = 1'h0;
    nb       = '0;

    s_d.pv_sck = s_sck;
    s_d.pv_nss = s_nss;
    s_d.pv_tgl = s_tgl;

    four_w   = (s_q.ss_mode == SS_MODE_4W);
    nss_fall = s_q.pv_nss & ~s_nss;
    smp_ev   = s_tgl ^ s_q.pv_tgl;
    shf_ev   = s_q.pv_sck & ~s_sck;

    // Three-wire slave ignores slave-select entirely
    slave_on = s_q.iface_en & ~s_q.mst_en & (four_w ? ~s_nss : (s_q.ss_mode == SS_MODE_3W));

    // Software control write; a 0 written to a flag bit clears it
    if (ctrl_wr) begin
      s_d.iface_en = ctrl_wdata[EN_BIT];
      s_d.mst_en   = ctrl_wdata[MST_BIT];
      s_d.ss_mode  = {ctrl_wdata[MODE_HI_BIT], ctrl_wdata[MODE_LO_BIT]};
      s_d.f_done   = s_q.f_done & ctrl_wdata[XFER_BIT];
      s_d.f_write_collision_flag   = s_q.f_write_collision_flag & ctrl_wdata[WRITE_COLLISION_FLAG_BIT];
      s_d.f_mode_fault_flag   = s_q.f_mode_fault_flag & ctrl_wdata[MODE_FAULT_FLAG_BIT];
      s_d.f_ovr    = s_q.f_ovr & ctrl_wdata[OVR_BIT];
    end

    if (data_rd) begin
      s_d.rx_full = 1'h0;
    end

    // Data write: only taken while the buffer is empty
    if (data_wr) begin
      if (s_q.tx_full) begin
        s_d.f_write_collision_flag = 1'h1;
      end else begin
        s_d.tx_buf  = data_wdata;
        s_d.tx_full = 1'h1;
      end
    end

    // Master sequencer, mode 0: rise samples, fall shifts
    case (s_q.mst)
      SEF_IDLE: begin
        s_d.sck = 1'h0;
        s_d.div = '0;
        if (s_q.iface_en && s_q.mst_en && s_q.tx_full) begin
          s_d.tx_sh   = s_q.tx_buf;
          s_d.tx_full = 1'h0;
          s_d.cnt     = '0;
          s_d.mst     = SEF_RUN;
        end
      end
      SEF_RUN: begin
        if (!(s_q.iface_en && s_q.mst_en)) begin
          s_d.mst = SEF_IDLE;
          s_d.sck = 1'h0;
        end else if (s_q.div == HALF_LAST) begin
          s_d.div = '0;
          s_d.sck = ~s_q.sck;
          if (!s_q.sck) begin
            s_d.rx_sh = shl_in(s_q.rx_sh, s_miso);
          end else begin
            s_d.tx_sh = shl_in(s_q.tx_sh, 1'h0);
            s_d.cnt   = s_q.cnt + CNT_W'(1);
            if (s_q.cnt == LAST_BIT) begin
              done    = 1'h1;
              nb      = s_q.rx_sh;
              s_d.mst = SEF_IDLE;
            end
          end
        end else begin
          s_d.div = s_q.div + DIV_W'(1);
        end
      end
      default: begin
        s_d.mst = SEF_IDLE;
      end
    endcase

    // Slave side
    if (!slave_on || (four_w && nss_fall)) begin
      if (!s_q.mst_en) begin
        s_d.cnt = '0;
      end
      s_d.sl_busy = 1'h0;
    end else begin
      // Buffer moves to the shifter only between bytes
      if (!s_q.sl_busy && s_q.tx_full && s_q.cnt == '0) begin
        s_d.tx_sh   = s_q.tx_buf;
        s_d.tx_full = 1'h0;
      end
      if (shf_ev && s_q.sl_busy) begin
        s_d.tx_sh = shl_in(s_q.tx_sh, 1'h0);
      end
      if (smp_ev) begin
        s_d.rx_sh   = shl_in(s_q.rx_sh, l_q.bit_v);
        s_d.sl_busy = 1'h1;
        s_d.cnt     = s_q.cnt + CNT_W'(1);
        if (s_q.cnt == LAST_BIT) begin
          done        = 1'h1;
          from_slv    = 1'h1;
          nb          = s_d.rx_sh;
          s_d.cnt     = '0;
          s_d.sl_busy = 1'h0;
        end
      end
    end

    // Byte finished: hardware only ever sets flags, after any clear
    if (done) begin
      s_d.f_done = 1'h1;
      if (from_slv && s_q.rx_full && !data_rd) begin
        s_d.f_ovr = 1'h1;
      end else begin
        s_d.rx_buf  = nb;
        s_d.rx_full = 1'h1;
      end
    end

    // Another master pulled slave-select while we were master
    if (s_q.iface_en && s_q.mst_en && four_w && !s_nss) begin
      s_d.f_mode_fault_flag   = 1'h1;
      s_d.mst_en   = 1'h0;
      s_d.iface_en = 1'h0;
      s_d.mst      = SEF_IDLE;
      s_d.sck      = 1'h0;
    end

    s_d.drv_mst = s_d.iface_en & s_d.mst_en;
    s_d.drv_slv = slave_on;
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    serial_control_reg              = 8'h00;
    serial_control_reg[XFER_BIT]    = s_q.f_done;
    serial_control_reg[WRITE_COLLISION_FLAG_BIT]    = s_q.f_write_collision_flag;
    serial_control_reg[MODE_FAULT_FLAG_BIT]    = s_q.f_mode_fault_flag;
    serial_control_reg[OVR_BIT]     = s_q.f_ovr;
    serial_control_reg[MODE_HI_BIT] = s_q.ss_mode[1];
    serial_control_reg[MODE_LO_BIT] = s_q.ss_mode[0];
    serial_control_reg[MST_BIT]     = s_q.mst_en;
    serial_control_reg[EN_BIT]      = s_q.iface_en;
  end

  assign irq             = int_en & (s_q.f_done | s_q.f_write_collision_flag | s_q.f_mode_fault_flag | s_q.f_ovr);
  assign serial_data_reg = s_q.rx_buf;
  assign sck_o           = s_q.sck;
  assign sck_oe          = s_q.drv_mst;
  assign mosi_o          = s_q.tx_sh[DW-1];
  assign mosi_oe         = s_q.drv_mst;
  // Shared shifter bit; one direction is enabled at a time, except for one cycle after a slave-to-master control write
  assign miso_o          = s_q.tx_sh[DW-1];
  assign miso_oe         = s_q.drv_slv;
  assign busy            = (s_q.mst == SEF_RUN) | s_q.sl_busy;

endmodule

`default_nettype wire

/* File: bench/sef_chk.sv */
/*
  Concurrent checks on the ports of sef_core, bound to every instance.
  Assumes the default HALF_CYC of 4 and a mode-0 link.
*/
`timescale 1ns/1ps
`default_nettype none
module sef_chk (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       sck_o,
  input wire logic       sck_oe,
  input wire logic       miso_oe,
  input wire logic       slave_select_n,
  input wire logic       ctrl_wr,
  input wire logic [7:0] serial_control_reg,
  input wire logic       int_en,
  input wire logic       irq,
  input wire logic       busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire logic [7:0] cr = serial_control_reg;
  wire logic       slv = (cr[3:0] == 4'h5);
  AST_IRQ: assert property (irq == (int_en && |cr[7:4]))
    else $error("irq does not follow flags");
  AST_STICKY: assert property (|($past(cr[7:4]) & ~cr[7:4]) |-> $past(ctrl_wr))
    else $error("flag dropped without a control write");
  AST_MODE_FAULT_FLAG_SET: assert property ((cr[3:0] == 4'h7 && !slave_select_n)[*3] |-> ##[1:3] cr[5])
    else $error("mode fault missed");
  AST_MODE_FAULT_FLAG_OFF: assert property ($rose(cr[5]) |-> cr[1:0] == 2'h0)
    else $error("enables kept on mode fault");
  // Exact four-cycle high half, low half at least four: stricter than the one-cycle floor
  AST_SCK_HI: assert property ($rose(sck_o) |-> sck_o[*4] ##1 !sck_o)
    else $error("serial clock high phase wrong");
  AST_SCK_LO: assert property ($fell(sck_o) && busy |-> !sck_o[*4])
    else $error("serial clock low phase short");
  AST_SEL_ON: assert property (slv && $fell(slave_select_n) |-> ##[1:4] miso_oe)
    else $error("slave output not driven in time");
  AST_SEL_OFF: assert property (cr[3:2] == 2'h1 && $rose(slave_select_n) |-> ##[0:4] !miso_oe)
    else $error("slave output not released in time");
  AST_IDLE: assert property ((slave_select_n && cr[3:2] == 2'h1)[*5] |-> !miso_oe)
    else $error("slave drives while deselected");
  AST_DONE: assert property (sck_oe && $fell(busy) |-> ##[0:2] cr[7])
    else $error("byte end without done flag");
endmodule
bind sef_core sef_chk sef_chk_inst (.clk_sys(clk_sys), .rst_b(rst_b), .sck_o(sck_o), .sck_oe(sck_oe),
  .miso_oe(miso_oe), .slave_select_n(slave_select_n), .ctrl_wr(ctrl_wr),
  .serial_control_reg(serial_control_reg), .int_en(int_en), .irq(irq), .busy(busy));
`default_nettype wire

/* File: bench/sef_peer.sv */
/*
  Far-side model: an external master for slave tests and a plain slave
  that answers the block's own master. Assumes mode-0 framing.
*/
`timescale 1ns/1ps
`default_nettype none
module sef_peer (
  input  wire logic sck_o,
  input  wire logic mosi_o,
  input  wire logic miso_o,
  input  wire logic miso_oe,
  output var logic  spi_sck,
  output var logic  mosi_i,
  output wire logic miso_i,
  output var logic  slave_select_n
);
  logic [7:0] stx_q = 8'h00;
  logic [7:0] srx_q = 8'h00;
  initial begin
    spi_sck = 1'b0;
    mosi_i = 1'b0;
    slave_select_n = 1'b1;
  end
  // Idle slave line toggles so a stale bit is never mistaken for data
  assign miso_i = miso_oe ? miso_o : stx_q[7];
  always @(posedge sck_o) srx_q <= {srx_q[6:0], mosi_o};
  always @(negedge sck_o) stx_q <= {stx_q[6:0], ~stx_q[0]};
  // Half period 60 ns keeps each phase above five system clocks
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #100 slave_select_n = 1'b0;
    #30;
    for (int i = 7; i >= 0; i--) begin
      mosi_i = tx[i];
      #60 spi_sck = 1'b1;
      rx[i] = miso_i;
      #60 spi_sck = 1'b0;
    end
    #30 slave_select_n = 1'b1;
    mosi_i = ~mosi_i;
  endtask
endmodule
`default_nettype wire

/* File: bench/tb_spi_event_flags_and_timing.sv */
/*
  Self-checking bench for sef_core with the far-side model.
  Assumes default parameters and software strobes at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_spi_event_flags_and_timing
  import sef_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       rst_b = 1'b0;
  logic       ctrl_wr = 1'b0;
  logic       data_wr = 1'b0;
  logic       data_rd = 1'b0;
  logic       int_en = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic [7:0] data_wdata = 8'h00;
  logic [7:0] serial_control_reg, serial_data_reg, got;
  logic       sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, busy;
  logic       spi_sck, mosi_i, miso_i, slave_select_n;
  int         miscompares = 0;
  int         checked = 0;
  always #5 clk_sys = ~clk_sys;
  sef_core sef_core_inst (.clk_sys, .rst_b, .spi_sck, .sck_o, .sck_oe, .mosi_i, .mosi_o, .mosi_oe, .miso_i,
    .miso_o, .miso_oe, .slave_select_n, .ctrl_wr, .ctrl_wdata, .serial_control_reg, .data_wr, .data_wdata,
    .data_rd, .serial_data_reg, .int_en, .irq, .busy);
  sef_peer sef_peer_inst (.sck_o, .mosi_o, .miso_o, .miso_oe, .spi_sck, .mosi_i, .miso_i, .slave_select_n);
  task automatic finish_test();
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Kind 0 control write, 1 data write, 2 receive read
  task automatic strobe(input int k, input logic [7:0] v);
    @(negedge clk_sys);
    ctrl_wr = (k == 0);
    data_wr = (k == 1);
    data_rd = (k == 2);
    ctrl_wdata = v;
    data_wdata = v;
    @(negedge clk_sys);
    ctrl_wr = 1'b0;
    data_wr = 1'b0;
    data_rd = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    while (serial_control_reg[b] !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (serial_control_reg[b] !== 1'b1) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic t_reset();
    cmp(serial_control_reg, 8'h04);
    cmp(serial_data_reg, 8'h00);
    cmp({4'h0, mosi_oe, irq, miso_oe, sck_oe}, 8'h00);
  endtask
  task automatic t_master();
    sef_peer_inst.stx_q = 8'h5A;
    strobe(0, 8'h07);
    cmp({6'h00, mosi_oe, sck_oe}, 8'h03);
    strobe(1, 8'hA5);
    wait_bit(XFER_BIT);
    cmp(serial_data_reg, 8'h5A);
    cmp(sef_peer_inst.srx_q, 8'hA5);
    int_en = 1'b1;
    #1 cmp({7'h00, irq}, 8'h01);
    strobe(0, 8'h07);
    cmp(serial_control_reg, 8'h07);
    strobe(2, 8'h00);
  endtask
  task automatic t_slave();
    strobe(0, 8'h05);
    strobe(1, 8'h3C);
    strobe(1, 8'hC3);
    cmp(serial_control_reg, 8'h45);
    sef_peer_inst.xfer(8'h96, got);
    cmp(got, 8'h3C);
    wait_bit(XFER_BIT);
    cmp(serial_data_reg, 8'h96);
    sef_peer_inst.xfer(8'h69, got);
    wait_bit(OVR_BIT);
    cmp(serial_data_reg, 8'h96);
    cmp(serial_control_reg, 8'hD5);
    strobe(2, 8'h00);
  endtask
  task automatic t_3w();
    strobe(0, 8'h01);
    strobe(1, 8'hE1);
    sef_peer_inst.xfer(8'h1E, got);
    cmp(got, 8'hE1);
    wait_bit(XFER_BIT);
    cmp(serial_data_reg, 8'h1E);
    cmp(serial_control_reg, 8'h81);
    strobe(2, 8'h00);
  endtask
  task automatic t_mode_fault_flag();
    strobe(0, 8'h07);
    sef_peer_inst.slave_select_n = 1'b0;
    wait_bit(MODE_FAULT_FLAG_BIT);
    @(negedge clk_sys);
    cmp(serial_control_reg, 8'h24);
    cmp({6'h00, mosi_oe, sck_oe}, 8'h00);
    cmp({7'h00, irq}, 8'h01);
    sef_peer_inst.slave_select_n = 1'b1;
    strobe(0, 8'h04);
    cmp({serial_control_reg[7:1], irq}, 8'h04);
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset();
    t_master();
    t_slave();
    t_3w();
    t_mode_fault_flag();
    finish_test();
  end
endmodule
`default_nettype wire
